/* File: common/ppi_pkg.sv */
// shared constants, register map and types of the pcie phy interface block
package ppi_pkg;

    // register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;

    // control register fields
    localparam int CTRL_GEN2 = 0;
    localparam int CTRL_SERDES = 1;
    localparam int CTRL_RMFIFO = 2;
    localparam int CTRL_MARGIN_LO = 4;
    localparam int CTRL_DEEMPH = 7;
    localparam logic [31:0] CTRL_RST = 32'h0000_0004;

    // status register fields
    localparam int STAT_PS_LO = 0;
    localparam int STAT_WIDE = 2;
    localparam int STAT_RATE5 = 3;
    localparam int STAT_FOUND = 4;
    localparam int STAT_RXST_LO = 5;

    // receive status codes
    localparam logic [2:0] RXST_OK = 3'h0;
    localparam logic [2:0] RXST_SKP_ADD = 3'h1;
    localparam logic [2:0] RXST_SKP_DEL = 3'h2;
    localparam logic [2:0] RXST_DETECTED = 3'h3;
    localparam logic [2:0] RXST_DEC_ERR = 3'h4;
    localparam logic [2:0] RXST_OVF = 3'h5;
    localparam logic [2:0] RXST_UNF = 3'h6;
    localparam logic [2:0] RXST_DISP_ERR = 3'h7;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PS_SETTLE_NS = 40;
    localparam int DET_TIMEOUT_NS = 10000;
    localparam logic [9:0] PS_SETTLE_CYC =
        10'((PS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] DET_TIMEOUT_CYC = 10'(DET_TIMEOUT_NS / CLK_PERIOD_NS);

    // power states as driven on the power-down input
    typedef enum logic [1:0] {
        PS_P0 = 2'b00,
        PS_P0S = 2'b01,
        PS_P1 = 2'b10,
        PS_P2 = 2'b11
    } ppi_pstate_t;

    // sequencer states
    typedef enum logic [3:0] {
        FS_IDLE = 4'b0001,
        FS_SETTLE = 4'b0010,
        FS_DETECT = 4'b0100,
        FS_DONE = 4'b1000
    } ppi_fsm_t;

    typedef struct packed {
        logic gen2_cap;
        logic serdes_en;
        logic rmfifo_en;
        logic [2:0] margin;
        logic deemph_6db;
    } ppi_cfg_t;

    // word handed to the 8b/10b encoder
    typedef struct packed {
        logic [15:0] data;
        logic [1:0] k;
        logic [1:0] force_neg;
        logic wide;
    } ppi_tx_t;

endpackage : ppi_pkg

/* File: design/ppi_rxstat.sv */
// receive status priority encoder
`timescale 1ns/10ps
module ppi_rxstat (
    // event flags for the current symbol
    input wire logic det_report,
    input wire logic dec_err,
    input wire logic rm_ovf,
    input wire logic rm_unf,
    input wire logic disp_err,
    input wire logic skp_add,
    input wire logic skp_del,
    // encoded status
    output logic [2:0] code
);

    // detection is reported alone, in the cycle its completion is signalled
    // priority encoding
    assign code = det_report ? ppi_pkg::RXST_DETECTED :
                  dec_err ? ppi_pkg::RXST_DEC_ERR :
                  rm_ovf ? ppi_pkg::RXST_OVF :
                  rm_unf ? ppi_pkg::RXST_UNF :
                  disp_err ? ppi_pkg::RXST_DISP_ERR :
                  skp_add ? ppi_pkg::RXST_SKP_ADD :
                  skp_del ? ppi_pkg::RXST_SKP_DEL :
                  ppi_pkg::RXST_OK;

endmodule : ppi_rxstat

/* File: design/ppi_top.sv */
// per-channel pcie phy interface block between the phy-mac and the coding datapath
`timescale 1ns/10ps
module ppi_top (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // phy-mac transmit and control
    input wire logic [15:0] tx_data,
    input wire logic [1:0] tx_k,
    input wire logic [1:0] disp_force,
    input wire logic force_idle,
    input wire logic detect_loopback,
    input wire logic [1:0] power_down,
    input wire logic rate_sel,
    // phy-mac receive and status
    output logic [15:0] rx_data,
    output logic [1:0] rx_k,
    output logic [2:0] rx_status,
    output logic phy_done,
    // transmit coding side
    output ppi_pkg::ppi_tx_t enc_out,
    output logic txbuf_idle,
    output logic txbuf_beacon,
    output logic loopback_en,
    output logic rxdet_start,
    output logic rate_5g,
    output logic [2:0] tx_margin,
    output logic tx_deemph_6db,
    // receive coding side
    input wire logic [15:0] dec_data,
    input wire logic [1:0] dec_k,
    input wire logic dec_err,
    input wire logic disp_err,
    input wire logic rm_ovf,
    input wire logic rm_unf,
    input wire logic skp_add,
    input wire logic skp_del,
    input wire logic align_sync,
    // analog detect circuit pins
    input wire logic rxdet_done_pin,
    input wire logic rxdet_found_pin
);

    ppi_pkg::ppi_cfg_t cfg;
    ppi_pkg::ppi_fsm_t fsm;
    ppi_pkg::ppi_fsm_t next_fsm;
    ppi_pkg::ppi_pstate_t cur_ps;
    ppi_pkg::ppi_pstate_t target_ps;
    logic [9:0] cnt;
    logic det_found;
    logic det_req_d;
    logic [2:0] done_sync;
    logic [2:0] found_sync;
    logic done_lvl;
    logic done_lvl_d;
    logic found_lvl;

    function automatic logic is_wide(input logic r5, input logic serdes);
        is_wide = r5 | serdes;
    endfunction : is_wide

    // one field map serves the reset word and writes, so the two cannot drift apart
    function automatic ppi_pkg::ppi_cfg_t ctrl_fields(input logic [31:0] w);
        ppi_pkg::ppi_cfg_t c;
        c.gen2_cap = w[ppi_pkg::CTRL_GEN2];
        c.serdes_en = w[ppi_pkg::CTRL_SERDES];
        c.rmfifo_en = w[ppi_pkg::CTRL_RMFIFO];
        c.margin = w[ppi_pkg::CTRL_MARGIN_LO +: 3];
        c.deemph_6db = w[ppi_pkg::CTRL_DEEMPH];
        return c;
    endfunction : ctrl_fields

    // 5 Gbps features gated by capability
    wire next_rate_5g = cfg.gen2_cap & rate_sel;
    // 5 Gbps forces the wide fabric word
    // at 2.5 Gbps width follows the byte serdes
    wire wide = is_wide(next_rate_5g, cfg.serdes_en);

    // register decode
    wire hit_ctrl = reg_addr == ppi_pkg::OFS_CTRL;
    wire hit_status = reg_addr == ppi_pkg::OFS_STATUS;
    wire [31:0] ctrl_word = {24'h0, cfg.deemph_6db, cfg.margin, 1'b0,
                             cfg.rmfifo_en, cfg.serdes_en, cfg.gen2_cap};
    wire [31:0] status_word = {24'h0, rx_status, det_found, rate_5g,
                               is_wide(rate_5g, cfg.serdes_en), cur_ps};
    wire [31:0] next_rdata = hit_ctrl ? ctrl_word : hit_status ? status_word : 32'h0;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg <= ctrl_fields(ppi_pkg::CTRL_RST);
            reg_rdata <= 32'h0;
        end else if (clk_en) begin
            if (reg_wr && hit_ctrl) begin
                cfg <= ctrl_fields(reg_wdata);
            end
            reg_rdata <= reg_rd ? next_rdata : 32'h0;
        end
    end

    // detect pins come from the analog side: three flops, change accepted when
    // the second and third agree, so a glitch shorter than a cycle is dropped
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_sync <= 3'h0;
            found_sync <= 3'h0;
            done_lvl <= 1'b0;
            done_lvl_d <= 1'b0;
            found_lvl <= 1'b0;
        end else if (clk_en) begin
            done_sync <= {done_sync[1:0], rxdet_done_pin};
            found_sync <= {found_sync[1:0], rxdet_found_pin};
            if (done_sync[1] == done_sync[2]) begin
                done_lvl <= done_sync[2];
            end
            if (found_sync[1] == found_sync[2]) begin
                found_lvl <= found_sync[2];
            end
            done_lvl_d <= done_lvl;
        end
    end

    wire done_rise = done_lvl & ~done_lvl_d;
    wire det_req_rise = detect_loopback & ~det_req_d;
    wire [1:0] pd_code = power_down;
    wire ps_change = pd_code != cur_ps;
    // detection may only start from P1
    wire det_go = (cur_ps == ppi_pkg::PS_P1) && det_req_rise && !ps_change;
    wire settle_end = (fsm == ppi_pkg::FS_SETTLE) && (cnt == 10'h1);
    wire det_end = (fsm == ppi_pkg::FS_DETECT) && (done_rise || cnt == 10'h1);
    wire det_report = (fsm == ppi_pkg::FS_DETECT) && done_rise && found_lvl;

    always_comb begin
        next_fsm = fsm;
        case (fsm)
            ppi_pkg::FS_IDLE: begin
                if (ps_change) begin
                    next_fsm = ppi_pkg::FS_SETTLE;
                end else if (det_go) begin
                    next_fsm = ppi_pkg::FS_DETECT;
                end
            end
            ppi_pkg::FS_SETTLE: begin
                if (settle_end) begin
                    next_fsm = ppi_pkg::FS_DONE;
                end
            end
            ppi_pkg::FS_DETECT: begin
                if (det_end) begin
                    next_fsm = ppi_pkg::FS_DONE;
                end
            end
            ppi_pkg::FS_DONE: begin
                next_fsm = ppi_pkg::FS_IDLE;
            end
            default: begin
                next_fsm = ppi_pkg::FS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fsm <= ppi_pkg::FS_IDLE;
            cnt <= 10'h0;
            det_req_d <= 1'b0;
            rxdet_start <= 1'b0;
        end else if (clk_en) begin
            fsm <= next_fsm;
            det_req_d <= detect_loopback;
            rxdet_start <= (fsm == ppi_pkg::FS_IDLE) && !ps_change && det_go;
            if (fsm == ppi_pkg::FS_IDLE && ps_change) begin
                cnt <= ppi_pkg::PS_SETTLE_CYC;
            end else if (fsm == ppi_pkg::FS_IDLE && det_go) begin
                cnt <= ppi_pkg::DET_TIMEOUT_CYC;
            end else if (cnt != 10'h0) begin
                cnt <= cnt - 10'h1;
            end
        end
    end

    // power-down code selects the state, applied after settling
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_ps <= ppi_pkg::PS_P1;
            target_ps <= ppi_pkg::PS_P1;
            det_found <= 1'b0;
        end else if (clk_en) begin
            if (fsm == ppi_pkg::FS_IDLE && ps_change) begin
                target_ps <= ppi_pkg::ppi_pstate_t'(pd_code);
            end
            if (settle_end) begin
                cur_ps <= target_ps;
            end
            if (det_end) begin
                det_found <= det_report;
            end
        end
    end

    // completion strobe for power changes and detection
    assign phy_done = (fsm == ppi_pkg::FS_DONE) && clk_en;

    // low power only means a held idle; P2 lifts it for beacon
    wire next_idle = force_idle || cur_ps == ppi_pkg::PS_P0S || cur_ps == ppi_pkg::PS_P1;
    // beacon only in P2, loopback only in P0
    wire next_beacon = (cur_ps == ppi_pkg::PS_P2) && !force_idle;
    wire next_loop = (cur_ps == ppi_pkg::PS_P0) && detect_loopback;

    // disparity force passes with the word; 8-bit uses lane 0 only
    // every word goes through this stage, there is no bypass path
    wire [1:0] next_force = disp_force & (wide ? 2'b11 : 2'b01);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            enc_out <= '0;
            txbuf_idle <= 1'b1;
            txbuf_beacon <= 1'b0;
            loopback_en <= 1'b0;
            rate_5g <= 1'b0;
            tx_margin <= 3'h0;
            tx_deemph_6db <= 1'b0;
        end else if (clk_en) begin
            enc_out.data <= wide ? tx_data : {8'h00, tx_data[7:0]};
            enc_out.k <= wide ? tx_k : {1'b0, tx_k[0]};
            enc_out.force_neg <= next_force;
            enc_out.wide <= wide;
            txbuf_idle <= next_idle;
            txbuf_beacon <= next_beacon;
            loopback_en <= next_loop;
            rate_5g <= next_rate_5g;
            tx_margin <= cfg.gen2_cap ? cfg.margin : 3'h0;
            tx_deemph_6db <= cfg.gen2_cap & cfg.deemph_6db;
        end
    end

    // symbol errors count only once the aligner reports sync
    wire err_ok = align_sync;
    // rate-match flags only when that buffer is in the path
    wire rm_ok = align_sync & cfg.rmfifo_en;
    wire [2:0] next_status;

    ppi_rxstat u_rxstat (
        .det_report(det_report),
        .dec_err(dec_err & err_ok),
        .rm_ovf(rm_ovf & rm_ok),
        .rm_unf(rm_unf & rm_ok),
        .disp_err(disp_err & err_ok),
        .skp_add(skp_add & rm_ok),
        .skp_del(skp_del & rm_ok),
        .code(next_status)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_data <= 16'h0;
            rx_k <= 2'h0;
            rx_status <= ppi_pkg::RXST_OK;
        end else if (clk_en) begin
            rx_data <= wide ? dec_data : {8'h00, dec_data[7:0]};
            rx_k <= wide ? dec_k : {1'b0, dec_k[0]};
            rx_status <= next_status;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    done_pulse_a: assert property (phy_done |=> !phy_done)
        else $error("phy done longer than one cycle");
    force_idle_a: assert property (clk_en && force_idle |=> txbuf_idle)
        else $error("force idle did not idle the buffer");
    lowpwr_idle_a: assert property (clk_en && (cur_ps == ppi_pkg::PS_P0S ||
        cur_ps == ppi_pkg::PS_P1) |=> txbuf_idle && !txbuf_beacon)
        else $error("low power state without electrical idle");
    wide_gen2_a: assert property (clk_en && cfg.gen2_cap && rate_sel
        |=> enc_out.wide && rate_5g)
        else $error("5 Gbps word not wide");
    narrow_gen1_a: assert property (clk_en && !next_rate_5g && !cfg.serdes_en
        |=> !enc_out.wide && enc_out.data[15:8] == 8'h00)
        else $error("2.5 Gbps without serdes not narrow");
    dec_prio_a: assert property (clk_en && dec_err && align_sync && !det_report
        |=> rx_status == ppi_pkg::RXST_DEC_ERR)
        else $error("decode error not reported first");
    ps_apply_a: assert property (clk_en && settle_end
        |=> cur_ps == $past(target_ps) ##1 !(fsm == ppi_pkg::FS_DONE))
        else $error("power state not applied on settle");
    det_in_p1_a: assert property (rxdet_start |-> cur_ps == ppi_pkg::PS_P1)
        else $error("detect started outside P1");
    gen2_gate_a: assert property (clk_en && !cfg.gen2_cap
        |=> tx_margin == 3'h0 && !tx_deemph_6db && !rate_5g)
        else $error("gen2 feature without capability");
    disp_pass_a: assert property (clk_en && disp_force[0]
        |=> enc_out.force_neg[0])
        else $error("disparity force lost");
    settle_time_a: assert property (clk_en && fsm == ppi_pkg::FS_IDLE && ps_change
        ##1 clk_en [*4] |=> phy_done)
        else $error("power change completion late");

    det_found_c: cover property (det_report ##1 phy_done);
    ps_done_c: cover property (settle_end ##1 phy_done);
    loop_c: cover property (loopback_en);
    beacon_c: cover property (txbuf_beacon);

endmodule : ppi_top

/* File: test/ppi_mac_model.sv */
// phy-mac side model: power commands, detect and loopback requests, compliance pattern
`timescale 1ns/10ps
module ppi_mac_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // commands from the bench
    input wire logic [1:0] ps_cmd,
    input wire logic det_req,
    input wire logic loop_req,
    input wire logic beacon_req,
    input wire logic comp_en,
    input wire logic wide,
    // pipe side of the block
    output logic [1:0] power_down,
    output logic force_idle,
    output logic detect_loopback,
    output logic [15:0] tx_data,
    output logic [1:0] tx_k,
    output logic [1:0] disp_force
);
    logic [1:0] phase;
    logic [15:0] seq;
    logic [8:0] s_lo;
    logic [8:0] s_hi;

    // {k, byte} of each compliance symbol
    function automatic logic [8:0] sym(input logic [1:0] p);
        case (p)
            2'h0, 2'h2: sym = 9'h1bc;
            2'h1: sym = 9'h0b5;
            default: sym = 9'h04a;
        endcase
    endfunction : sym

    assign power_down = ps_cmd;
    assign force_idle = (ps_cmd == 2'h0) ? 1'b0 : (ps_cmd == 2'h3) ? !beacon_req : 1'b1;
    // detect only in p1, loopback only in p0
    assign detect_loopback = (ps_cmd == 2'h2) ? det_req : (ps_cmd == 2'h0) ? loop_req : 1'b0;
    assign s_lo = sym(phase);
    assign s_hi = sym(phase + 2'h1);
    assign tx_data = !comp_en ? seq : wide ? {s_hi[7:0], s_lo[7:0]} : {8'h00, s_lo[7:0]};
    assign tx_k = !comp_en ? 2'h0 : wide ? {s_hi[8], s_lo[8]} : {1'b0, s_lo[8]};
    // only bit 0, with the first k28.5
    assign disp_force = (comp_en && phase == 2'h0) ? 2'h1 : 2'h0;

    always_ff @(posedge sys_clk) begin
        if (rst || !comp_en) begin
            phase <= 2'h0;
        end else begin
            phase <= wide ? phase + 2'h2 : phase + 2'h1;
        end
    end

    // idle traffic changes every cycle so stale data never matches
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seq <= 16'h0000;
        end else begin
            seq <= seq + 16'h0101;
        end
    end
endmodule : ppi_mac_model

/* File: test/test_pcie_phy_interface_block.sv */
// self-checking bench of the pcie phy interface block
`timescale 1ns/10ps
module test_pcie_phy_interface_block;
    logic sys_clk, rst, clk_en, reg_wr, reg_rd, det_req, loop_req, beacon_req;
    logic comp_en, wide_req, rate_sel, force_idle, detect_loopback, phy_done;
    logic txbuf_idle, txbuf_beacon, loopback_en, rxdet_start, rate_5g, tx_deemph_6db;
    logic align_sync, done_pin, found_pin;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [1:0] ps_cmd, power_down, tx_k, disp_force, rx_k, dec_k;
    logic [15:0] tx_data, rx_data, dec_data;
    logic [2:0] rx_status, tx_margin;
    logic [5:0] rx_flags;
    ppi_pkg::ppi_tx_t enc_out;
    int bad_count, num_checks, n, hits;
    logic [5:0] flag_tab [7] = '{6'h24, 6'h18, 6'h0c, 6'h06, 6'h03, 6'h01, 6'h00};
    logic [2:0] code_tab [7] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h0};

    ppi_mac_model i_mac (.sys_clk(sys_clk), .rst(rst), .ps_cmd(ps_cmd), .det_req(det_req),
        .loop_req(loop_req), .beacon_req(beacon_req), .comp_en(comp_en), .wide(wide_req),
        .power_down(power_down), .force_idle(force_idle), .detect_loopback(detect_loopback),
        .tx_data(tx_data), .tx_k(tx_k), .disp_force(disp_force));

    ppi_top i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_data(tx_data), .tx_k(tx_k), .disp_force(disp_force), .force_idle(force_idle),
        .detect_loopback(detect_loopback), .power_down(power_down), .rate_sel(rate_sel),
        .rx_data(rx_data), .rx_k(rx_k), .rx_status(rx_status), .phy_done(phy_done),
        .enc_out(enc_out), .txbuf_idle(txbuf_idle), .txbuf_beacon(txbuf_beacon),
        .loopback_en(loopback_en), .rxdet_start(rxdet_start), .rate_5g(rate_5g),
        .tx_margin(tx_margin), .tx_deemph_6db(tx_deemph_6db), .dec_data(dec_data),
        .dec_k(dec_k), .dec_err(rx_flags[5]), .rm_ovf(rx_flags[4]), .rm_unf(rx_flags[3]),
        .disp_err(rx_flags[2]), .skp_add(rx_flags[1]), .skp_del(rx_flags[0]),
        .align_sync(align_sync), .rxdet_done_pin(done_pin), .rxdet_found_pin(found_pin));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic wait_done(output int cnt);
        cnt = 0;
        do begin
            tick();
            cnt++;
        end while (phy_done !== 1'b1 && cnt < 1100);
    endtask : wait_done

    task automatic go_ps(input logic [1:0] ps);
        int cnt;
        logic [31:0] d;
        @(posedge sys_clk);
        ps_cmd <= ps;
        wait_done(cnt);
        chk(cnt, 5, "power change latency");
        tick();
        chk(phy_done, 0, "done pulse width");
        chk(txbuf_idle, ps != 2'h0 && !(ps == 2'h3 && beacon_req), "tx idle");
        chk(txbuf_beacon, ps == 2'h3 && beacon_req, "beacon");
        chk(loopback_en, ps == 2'h0 && loop_req, "loopback");
        reg_read(ppi_pkg::OFS_STATUS, d);
        chk(d[1:0], ps, "power state field");
    endtask : go_ps

    task automatic print_verdict;
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // far beyond the roughly 1200 cycles the sequence needs
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end

    initial begin
        {rst, clk_en, align_sync} = 3'h7;
        {reg_wr, reg_rd, det_req, loop_req, beacon_req, comp_en, wide_req, rate_sel} = 8'h00;
        {done_pin, found_pin, rx_flags, reg_addr, reg_wdata} = '0;
        ps_cmd = 2'h2;
        dec_data = 16'ha5c3;
        dec_k = 2'h2;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        tick();
        chk(txbuf_idle, 1, "idle after reset");
        reg_read(ppi_pkg::OFS_CTRL, v);
        chk(v, ppi_pkg::CTRL_RST, "ctrl reset");
        reg_write(ppi_pkg::OFS_STATUS, 32'hffff_ffff);
        reg_write(4'h8, 32'hffff_ffff);
        reg_read(4'h8, v);
        chk(v, 0, "unmapped read");
        reg_read(ppi_pkg::OFS_STATUS, v);
        chk(v, 32'h0000_0002, "status after reset");
        @(posedge sys_clk);
        det_req <= 1'b1;
        n = 0;
        repeat (4) begin
            tick();
            n += rxdet_start;
        end
        chk(n, 1, "detect start pulse");
        @(posedge sys_clk);
        {done_pin, found_pin} <= 2'h3;
        wait_done(n);
        chk(n <= 8, 1, "detect done latency");
        chk(rx_status, 3'h3, "receiver detected");
        @(posedge sys_clk);
        {done_pin, found_pin, det_req} <= 3'h0;
        reg_read(ppi_pkg::OFS_STATUS, v);
        chk(v[4], 1, "found flag");
        @(posedge sys_clk);
        det_req <= 1'b1;
        wait_done(n);
        chk(n >= 990 && n <= 1010, 1, "detect timeout");
        chk(rx_status, 3'h0, "no receiver");
        @(posedge sys_clk);
        det_req <= 1'b0;
        loop_req <= 1'b1;
        go_ps(2'h0);
        @(posedge sys_clk);
        loop_req <= 1'b0;
        for (int w = 0; w < 2; w++) begin
            if (w == 1) reg_write(ppi_pkg::OFS_CTRL, 32'h0000_0006);
            @(posedge sys_clk);
            {comp_en, wide_req} <= {1'b1, w[0]};
            repeat (3) tick();
            hits = 0;
            repeat (8) begin
                tick();
                chk(enc_out.wide, w, "lane width");
                chk(enc_out.force_neg[1], 0, "upper force bit");
                if (w == 0) chk(enc_out.data[15:8], 0, "narrow upper byte");
                if (enc_out.force_neg[0] === 1'b1) begin
                    hits++;
                    chk(enc_out.data[7:0], 8'hbc, "forced symbol");
                    chk(enc_out.k[0], 1, "forced symbol k");
                end
            end
            chk(hits, w ? 4 : 2, "force count");
            @(posedge sys_clk);
            comp_en <= 1'b0;
        end
        @(posedge sys_clk);
        rate_sel <= 1'b1;
        reg_write(ppi_pkg::OFS_CTRL, 32'h0000_00d6);
        repeat (2) tick();
        chk({rate_5g, tx_margin, tx_deemph_6db}, 5'h00, "gen2 off");
        reg_write(ppi_pkg::OFS_CTRL, 32'h0000_00d5);
        repeat (2) tick();
        chk({rate_5g, tx_margin, tx_deemph_6db}, 5'h1b, "gen2 on");
        chk(enc_out.wide, 1, "5g width");
        reg_read(ppi_pkg::OFS_CTRL, v);
        chk(v, 32'h0000_00d5, "ctrl readback");
        reg_read(ppi_pkg::OFS_STATUS, v);
        chk(v[3:2], 2'h3, "rate and width");
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            rx_flags <= flag_tab[i];
            tick();
            chk(rx_status, code_tab[i], "status priority");
            chk({rx_k, rx_data}, 18'h2a5c3, "rx data");
        end
        @(posedge sys_clk);
        {align_sync, rx_flags} <= 7'h20;
        tick();
        chk(rx_status, 3'h0, "unaligned errors");
        reg_write(ppi_pkg::OFS_CTRL, 32'h0000_00d1);
        {align_sync, rx_flags} <= 7'h50;
        repeat (2) tick();
        chk(rx_status, 3'h0, "fifo off");
        // enable low must hold the receive status and the tx word while inputs keep moving
        @(posedge sys_clk);
        {clk_en, rx_flags} <= 7'h24;
        tick();
        v = {16'h0, enc_out.data};
        repeat (2) tick();
        chk(rx_status, 3'h0, "frozen status");
        chk({16'h0, enc_out.data}, v, "frozen tx word");
        @(posedge sys_clk);
        clk_en <= 1'b1;
        tick();
        chk(rx_status, 3'h4, "status after thaw");
        @(posedge sys_clk);
        rx_flags <= 6'h00;
        go_ps(2'h1);
        go_ps(2'h3);
        // beacon only once P2 is reached, so force-idle never drops in P0s
        @(posedge sys_clk);
        beacon_req <= 1'b1;
        repeat (2) tick();
        chk({txbuf_idle, txbuf_beacon}, 2'h1, "beacon in P2");
        @(posedge sys_clk);
        beacon_req <= 1'b0;
        go_ps(2'h2);
        print_verdict();
    end
endmodule : test_pcie_phy_interface_block
